/* fsp_top.sv */
// Purpose: serial flash command front end: ident read, status read, status write, protection
// Assumes: MCLK much faster than serial clock; pins synchronised before use
// Notes: memory array not modelled; program and erase only run a busy timer
`timescale 1ns/1ns
// Function
// - ident command shifts out 20 bytes: maker, type, capacity, length, 16 data.
// - ident output bits change on falling serial clock.
// - ident command ignored while program or erase runs.
// - customer bytes read-only, zero unless loaded.
// - chip select high ends ident read, back to standby.
// - status read accepted anytime, repeats while selected.
// - busy bit is one during status-write, program or erase.
// - write-enable bit mirrors latch; zero rejects writes.
// - block-protect bits only via status-write; refuse protected program/erase.
// - bulk erase only when all block-protect bits are zero.
// - disable bit set and protect pin low: status writes refused.
// - status-write is command plus one data byte, needs latch set.
// - status-write keeps bits 7,4,3,2; bits 6,5 read zero.
// - chip select must rise right after eighth data bit, else discarded.
// - valid status-write starts timed cycle, then clears busy and latch.
// - disable bit zero: status writable after write-enable regardless of pin.
// - disable bit one and pin high: still writable with latch.
// - hardware protection enters in either order of bit and pin.
// - only protect pin high leaves hardware protection.
// - all bits shifted most significant first.
// - data-in sampled on rising serial clock from first edge after select.
// - latch cleared at power-up and after disable, status-write, program, erase.
module fsp_top #(
    parameter int WRITE_CYCLES = fsp_pkg::STATUS_WRITE_CYCLES,
    parameter int PROG_CYCLES = fsp_pkg::PROG_CYCLES,
    parameter int ERASE_CYCLES = fsp_pkg::ERASE_CYCLES,
    parameter logic [7:0] MAKER_ID = 8'h5a,
    parameter logic [7:0] TYPE_ID = 8'h3c,
    parameter logic [7:0] CAPACITY_ID = 8'h2b
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CS_N,
    input wire logic SCK,
    input wire logic SDI,
    input wire logic WP_N,
    input wire logic [127:0] CFD_LOAD,
    output logic SDO,
    output logic SDO_OE_N,
    output logic BUSY
);
    // maker, type, capacity ids are arbitrary neutral values
    initial begin
        if (WRITE_CYCLES < 1 || PROG_CYCLES < 1 || ERASE_CYCLES < 1) $error("cycle counts must be positive");
    end

    // ==========================================
    // pin synchronisation
    logic [3:0] pins_s;
    fsp_sync #(.W(4)) u_sync (
        .clk(MCLK),
        .rst(RST),
        .d({~CS_N, SCK, SDI, WP_N}),
        .q(pins_s)
    );
    logic sel, sck, sdi, wp_n;
    assign sel = pins_s[3];
    assign sck = pins_s[2];
    assign sdi = pins_s[1];
    assign wp_n = pins_s[0];

    // ==========================================
    // state
    typedef struct packed {
        logic sck_d;
        logic sel_d;
        fsp_pkg::fsp_phase_t phase;
        logic [2:0] bitc;
        logic [7:0] cmd;
        logic [7:0] shin;
        logic [4:0] byte_idx;
        logic [7:0] shout;
        logic [7:0] wsr_data;
        logic wsr_ok;
        logic [1:0] addr_cnt;
        logic write_enable_latch;
        logic [2:0] bp;
        logic swd;
        logic busy;
        logic [31:0] timer;
        logic sdo;
        logic sdo_oe_n;
    } fsp_state_t;
    fsp_state_t st_r, st_nxt;

    // serial events from edge detection, via fifo to keep strict order
    logic rise, fall, desel;
    assign rise = sel && sck && !st_r.sck_d;
    assign fall = sel && !sck && st_r.sck_d;
    assign desel = !sel && st_r.sel_d;
    logic ev_valid, ev_ready;
    logic [8:0] ev_data;
    logic fifo_in_ready;
    // ev_data: {desel, fall, rise, ..., sdi}
    fsp_fifo #(.WIDTH(9), .DEPTH(8)) u_fifo (
        .clk(MCLK),
        .rst(RST),
        .in_valid(rise || fall || desel),
        .in_ready(fifo_in_ready),
        .in_data({desel, fall, rise, 5'h00, sdi}),
        .out_valid(ev_valid),
        .out_ready(ev_ready),
        .out_data(ev_data)
    );
    assign ev_ready = 1'b1;
    logic e_rise, e_fall, e_desel, e_bit;
    assign e_rise = ev_valid && ev_data[6];
    assign e_fall = ev_valid && ev_data[7];
    assign e_desel = ev_valid && ev_data[8];
    assign e_bit = ev_data[0];

    function automatic logic [7:0] status_of(input fsp_state_t s);
        logic [7:0] v;
        v = 8'h00;
        v[fsp_pkg::BUSY_POS] = s.busy;
        v[fsp_pkg::WEL_POS] = s.write_enable_latch;
        v[fsp_pkg::BP_HI:fsp_pkg::BP_LO] = s.bp;
        v[fsp_pkg::SWD_POS] = s.swd;
        return v; // bits 6,5 stay zero
    endfunction

    function automatic logic [7:0] ident_byte(input logic [4:0] i, input logic [127:0] cfd);
        logic [7:0] v;
        v = fsp_pkg::CFD_DEFAULT;
        case (i)
            5'h00: v = MAKER_ID;
            5'h01: v = TYPE_ID;
            5'h02: v = CAPACITY_ID;
            5'h03: v = fsp_pkg::UID_LEN;
            default: begin
                if (i < 5'(fsp_pkg::IDENT_BYTES)) v = cfd[8'(127 - 8 * (i - 4)) -: 8];
            end
        endcase
        return v;
    endfunction

    logic hw_prot;
    assign hw_prot = st_r.swd && !wp_n;

    always_comb begin
        logic [7:0] byte_in;
        byte_in = {st_r.shin[6:0], e_bit};
        st_nxt = st_r;
        st_nxt.sck_d = sck;
        st_nxt.sel_d = sel;
        // self-timed cycle
        if (st_r.busy) begin
            if (st_r.timer <= 32'd1) begin
                st_nxt.busy = 1'b0;
                st_nxt.write_enable_latch = 1'b0;
                st_nxt.timer = 32'd0;
                if (st_r.wsr_ok) begin
                    st_nxt.bp = st_r.wsr_data[fsp_pkg::BP_HI:fsp_pkg::BP_LO];
                    st_nxt.swd = st_r.wsr_data[fsp_pkg::SWD_POS];
                    st_nxt.wsr_ok = 1'b0;
                end
            end else begin
                st_nxt.timer = st_r.timer - 32'd1;
            end
        end
        if (e_desel) begin
            // byte boundary check for write-type commands
            if (st_r.bitc == 3'd0 && !st_r.busy && st_r.write_enable_latch) begin
                if (st_r.phase == fsp_pkg::FSP_DATA && st_r.byte_idx == 5'd1 && st_r.cmd == fsp_pkg::WRITE_STATUS_CMD
                    && !hw_prot) begin
                    st_nxt.busy = 1'b1;
                    st_nxt.wsr_ok = 1'b1;
                    st_nxt.timer = 32'(WRITE_CYCLES);
                end else if (st_r.phase == fsp_pkg::FSP_ADDR && st_r.addr_cnt == 2'd3 && st_r.bp == 3'b000) begin
                    // protected area table omitted: any set protect bit refuses
                    st_nxt.busy = 1'b1;
                    st_nxt.timer = (st_r.cmd == fsp_pkg::SECTOR_ERASE_CMD) ? 32'(ERASE_CYCLES) : 32'(PROG_CYCLES);
                end else if (st_r.phase == fsp_pkg::FSP_SKIP && st_r.cmd == fsp_pkg::BULK_ERASE_CMD
                             && st_r.bp == 3'b000) begin
                    st_nxt.busy = 1'b1;
                    st_nxt.timer = 32'(ERASE_CYCLES);
                end
            end
            if (st_r.bitc == 3'd0 && st_r.phase == fsp_pkg::FSP_SKIP && st_r.cmd == fsp_pkg::SET_WRITE_ENABLE_CMD
                && !st_r.busy) st_nxt.write_enable_latch = 1'b1;
            if (st_r.bitc == 3'd0 && st_r.phase == fsp_pkg::FSP_SKIP && st_r.cmd == fsp_pkg::CLEAR_WRITE_ENABLE_CMD
                && !st_r.busy) st_nxt.write_enable_latch = 1'b0;
            st_nxt.phase = fsp_pkg::FSP_IDLE;
            st_nxt.bitc = 3'd0;
            st_nxt.sdo_oe_n = 1'b1;
        end else if (e_rise) begin
            st_nxt.shin = byte_in;
            st_nxt.bitc = st_r.bitc + 3'd1;
            if (st_r.phase == fsp_pkg::FSP_IDLE) st_nxt.phase = fsp_pkg::FSP_CMD;
            if (st_r.bitc == 3'd7) begin
                if (st_r.phase == fsp_pkg::FSP_IDLE || st_r.phase == fsp_pkg::FSP_CMD) begin
                    st_nxt.cmd = byte_in;
                    st_nxt.byte_idx = 5'd0;
                    st_nxt.addr_cnt = 2'd0;
                    st_nxt.phase = fsp_pkg::FSP_SKIP;
                    unique case (byte_in)
                        fsp_pkg::READ_IDENT_CMD: begin
                            if (!st_r.busy) begin
                                st_nxt.phase = fsp_pkg::FSP_OUT;
                                st_nxt.shout = ident_byte(5'd0, CFD_LOAD);
                                st_nxt.byte_idx = 5'd1;
                            end
                        end
                        fsp_pkg::READ_STATUS_CMD: begin
                            st_nxt.phase = fsp_pkg::FSP_OUT;
                            st_nxt.shout = status_of(st_r);
                        end
                        fsp_pkg::WRITE_STATUS_CMD: st_nxt.phase = fsp_pkg::FSP_DATA;
                        fsp_pkg::PAGE_PROGRAM_CMD, fsp_pkg::SECTOR_ERASE_CMD: st_nxt.phase = fsp_pkg::FSP_ADDR;
                        default: st_nxt.phase = fsp_pkg::FSP_SKIP;
                    endcase
                end else if (st_r.phase == fsp_pkg::FSP_DATA) begin
                    if (st_r.byte_idx == 5'd0) begin
                        st_nxt.wsr_data = byte_in & fsp_pkg::STATUS_WRITABLE_MASK;
                        st_nxt.byte_idx = 5'd1;
                    end else begin
                        st_nxt.byte_idx = 5'd2; // extra byte discards
                    end
                end else if (st_r.phase == fsp_pkg::FSP_ADDR) begin
                    // page data bytes not modelled; only the address phase is tracked
                    if (st_r.addr_cnt != 2'd3) st_nxt.addr_cnt = st_r.addr_cnt + 2'd1;
                    else if (st_r.cmd == fsp_pkg::SECTOR_ERASE_CMD) st_nxt.phase = fsp_pkg::FSP_SKIP;
                end
            end
        end else if (e_fall && st_r.phase == fsp_pkg::FSP_OUT) begin
            st_nxt.sdo = st_r.shout[7];
            st_nxt.sdo_oe_n = 1'b0;
            if (st_r.bitc == 3'd0) begin
                // fresh byte at boundary, its first bit driven out on this edge
                if (st_r.cmd == fsp_pkg::READ_STATUS_CMD) begin
                    st_nxt.sdo = st_r.shout[7];
                end
                st_nxt.shout = {st_r.shout[6:0], 1'b0};
            end else begin
                st_nxt.shout = {st_r.shout[6:0], 1'b0};
                if (st_r.bitc == 3'd7) begin
                    if (st_r.cmd == fsp_pkg::READ_STATUS_CMD) begin
                        st_nxt.shout = status_of(st_r);
                    end else if (st_r.byte_idx < 5'(fsp_pkg::IDENT_BYTES)) begin
                        st_nxt.shout = ident_byte(st_r.byte_idx, CFD_LOAD);
                        st_nxt.byte_idx = st_r.byte_idx + 5'd1;
                    end else begin
                        st_nxt.shout = 8'h00;
                    end
                end
            end
        end
        if (e_rise && st_r.phase == fsp_pkg::FSP_OUT) begin
            st_nxt.phase = fsp_pkg::FSP_OUT;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            st_r <= '{phase: fsp_pkg::FSP_IDLE, sdo_oe_n: 1'b1, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            SDO <= 1'b0;
            SDO_OE_N <= 1'b1;
            BUSY <= 1'b0;
        end else begin
            SDO <= st_nxt.sdo;
            SDO_OE_N <= st_nxt.sdo_oe_n;
            BUSY <= st_nxt.busy;
        end
    end

    // ==========================================
    // checks
    logic [7:0] status_now;
    assign status_now = status_of(st_r);
    a_busy_wel_clear: assert property (@(posedge MCLK) disable iff (RST)
        $fell(st_r.busy) |-> !st_r.write_enable_latch) else $error("latch not cleared after cycle");
    a_hw_prot_block: assert property (@(posedge MCLK) disable iff (RST)
        (hw_prot && !st_r.busy) |=> !(st_r.wsr_ok && $rose(st_r.busy))) else $error("write in protect");
    a_wel_needed: assert property (@(posedge MCLK) disable iff (RST)
        $rose(st_r.busy) |-> $past(st_r.write_enable_latch)) else $error("cycle without latch");
    a_bulk_bp: assert property (@(posedge MCLK) disable iff (RST)
        ($rose(st_r.busy) && !st_r.wsr_ok) |-> $past(st_r.bp) == 3'b000) else $error("protected erase");
    a_bits_zero: assert property (@(posedge MCLK) disable iff (RST)
        status_now[6:5] == 2'b00) else $error("reserved bits set");
    a_busy_out: assert property (@(posedge MCLK) disable iff (RST)
        ##1 BUSY == st_r.busy) else $error("busy pin mismatch");
    a_desel_idle: assert property (@(posedge MCLK) disable iff (RST)
        e_desel |=> (st_r.phase == fsp_pkg::FSP_IDLE && st_r.sdo_oe_n)) else $error("no standby");
    a_fifo_room: assert property (@(posedge MCLK) disable iff (RST)
        fifo_in_ready) else $error("event fifo overflow");
    a_sdo_on_fall: assert property (@(posedge MCLK) disable iff (RST)
        $changed(st_r.sdo) |-> $past(e_fall)) else $error("sdo moved off falling edge");

    // ==========================================
    // multi-step checks
    sequence s_cmd_done;
        e_rise && st_r.bitc == 3'd7 && st_r.phase == fsp_pkg::FSP_CMD;
    endsequence
    sequence s_ident_cmd;
        s_cmd_done ##0 {st_r.shin[6:0], e_bit} == fsp_pkg::READ_IDENT_CMD;
    endsequence
    sequence s_set_write_enable_cmd_end;
        e_desel && st_r.bitc == 3'd0 && st_r.phase == fsp_pkg::FSP_SKIP
            && st_r.cmd == fsp_pkg::SET_WRITE_ENABLE_CMD;
    endsequence
    // a cut or overlong status-write frame must never start a cycle
    sequence s_wsr_end;
        e_desel && st_r.phase == fsp_pkg::FSP_DATA
            && st_r.cmd == fsp_pkg::WRITE_STATUS_CMD;
    endsequence

    a_ident_busy: assert property (@(posedge MCLK) disable iff (RST)
        s_ident_cmd ##0 st_r.busy |=> st_r.phase == fsp_pkg::FSP_SKIP)
        else $error("ident decoded while busy");

    a_ident_first: assert property (@(posedge MCLK) disable iff (RST)
        s_ident_cmd ##0 !st_r.busy |=> st_r.shout == MAKER_ID && st_r.byte_idx == 5'd1)
        else $error("ident not started");

    a_status_any: assert property (@(posedge MCLK) disable iff (RST)
        s_cmd_done ##0 {st_r.shin[6:0], e_bit} == fsp_pkg::READ_STATUS_CMD |=> st_r.phase == fsp_pkg::FSP_OUT)
        else $error("status read refused");

    a_set_write_enable_cmd_sets: assert property (@(posedge MCLK) disable iff (RST)
        s_set_write_enable_cmd_end ##0 !st_r.busy |=> st_r.write_enable_latch)
        else $error("latch not set");

    a_wsr_start: assert property (@(posedge MCLK) disable iff (RST)
        s_wsr_end ##0 (st_r.bitc == 3'd0 && st_r.byte_idx == 5'd1 && st_r.write_enable_latch && !st_r.busy && !hw_prot)
        |=> st_r.busy && st_r.wsr_ok) else $error("status-write not started");

    a_wsr_discard: assert property (@(posedge MCLK) disable iff (RST)
        s_wsr_end ##0 (!st_r.busy && st_r.byte_idx != 5'd1) |=> !st_r.busy)
        else $error("bad frame started a cycle");

    a_wsr_commit: assert property (@(posedge MCLK) disable iff (RST)
        $fell(st_r.busy) && $past(st_r.wsr_ok) |-> st_r.bp == $past(st_r.wsr_data[fsp_pkg::BP_HI:fsp_pkg::BP_LO]))
        else $error("protect bits not committed");
endmodule

/* fsp_pkg.sv */
// Purpose: shared constants and types for the flash status, ident and protect logic
// Assumes: one system clock MCLK at 250 MHz, serial pins oversampled
// Notes: status byte layout and command codes live here
package fsp_pkg;
    // ==========================================
    // command codes
    localparam logic [7:0] SET_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] CLEAR_WRITE_ENABLE_CMD = 8'h04;
    localparam logic [7:0] READ_IDENT_CMD = 8'h9f;
    localparam logic [7:0] READ_STATUS_CMD = 8'h05;
    localparam logic [7:0] WRITE_STATUS_CMD = 8'h01;
    localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
    localparam logic [7:0] SECTOR_ERASE_CMD = 8'hd8;
    localparam logic [7:0] BULK_ERASE_CMD = 8'hc7;
    // ==========================================
    // status field positions
    localparam int BUSY_POS = 0;
    localparam int WEL_POS = 1;
    localparam int BP_LO = 2;
    localparam int BP_HI = 4;
    localparam int SWD_POS = 7;
    localparam logic [7:0] STATUS_WRITABLE_MASK = 8'h9c;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // ==========================================
    // ident layout
    localparam int IDENT_BYTES = 20;
    localparam int CFD_BYTES = 16;
    localparam logic [7:0] UID_LEN = 8'h10;
    localparam logic [7:0] CFD_DEFAULT = 8'h00;
    // ==========================================
    // timing
    localparam int CLK_MHZ = 250;
    localparam int STATUS_WRITE_TIME_US = 15;
    localparam int STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_US * CLK_MHZ;
    localparam int PROG_CYCLES = 2000;
    localparam int ERASE_CYCLES = 4000;
    typedef enum logic [2:0] {
        FSP_IDLE = 3'b000,
        FSP_CMD = 3'b001,
        FSP_OUT = 3'b011,
        FSP_DATA = 3'b010,
        FSP_ADDR = 3'b110,
        FSP_SKIP = 3'b111
    } fsp_phase_t;
endpackage

/* fsp_sync.sv */
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to MCLK
// Notes: first stage read only by second
`timescale 1ns/1ns
module fsp_sync #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

/* fsp_fifo.sv */
// Purpose: small flip-flop fifo between serial input and command logic
// Assumes: single clock
// Notes: depth power of two
`timescale 1ns/1ns
module fsp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be power of two");
    end
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wp_r, rp_r;
    logic full, push, pop;
    assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = wp_r != rp_r;
    assign out_data = mem_r[rp_r[AW-1:0]];
    assign push = in_valid && !full;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push) wp_r <= wp_r + 1'b1;
            if (pop) rp_r <= rp_r + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (push) mem_r[wp_r[AW-1:0]] <= in_data;
    end
endmodule

/* fsp_host.sv */
// Purpose: behavioural host serial controller for the flash front end
// Assumes: mode 0, serial half period of HALF system clocks
// Notes: pins change only on the falling system clock edge
`timescale 1ns/1ns
module fsp_host #(
    parameter int HALF = 8
) (
    input wire logic mclk,
    output logic cs_n,
    output logic sck,
    output logic sdi,
    input wire logic sdo
);
    // ==========================================
    // pin tasks
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic sel();
        wait_clk(1);
        cs_n = 1'b0;
        wait_clk(HALF);
    endtask
    // one byte each way, serial data-out taken at the rising edge
    task automatic xb(input logic [7:0] o, output logic [7:0] i);
        for (int b = 7; b >= 0; b--) begin
            sdi = o[b];
            wait_clk(HALF);
            sck = 1'b1;
            i[b] = sdo;
            wait_clk(HALF);
            sck = 1'b0;
        end
    endtask
    // select rises only on a byte boundary
    task automatic desel();
        wait_clk(HALF);
        cs_n = 1'b1;
        sdi = ~sdi; // released line must not keep its last level
        wait_clk(2 * HALF);
    endtask
    task automatic cmd(input logic [7:0] c);
        logic [7:0] d;
        sel();
        xb(c, d);
        desel();
    endtask
endmodule

/* tb_fsp_top.sv */
// Purpose: self-checking bench for the flash status, ident and protect front end
// Assumes: host model drives the serial pins, bench drives reset, protect pin, customer data
// Notes: timed cycles shortened by parameter to keep the run short
`timescale 1ns/1ns
module tb_fsp_top;
    // ==========================================
    // set-up
    localparam logic [7:0] MAKER = 8'h5a; // arbitrary
    localparam logic [7:0] MTYPE = 8'h3c; // arbitrary
    localparam logic [7:0] MCAP = 8'h2b; // arbitrary
    localparam logic [7:0] C_WE = fsp_pkg::SET_WRITE_ENABLE_CMD;
    localparam logic [7:0] C_RS = fsp_pkg::READ_STATUS_CMD;
    localparam logic [7:0] C_ID = fsp_pkg::READ_IDENT_CMD;
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic WP_N = 1'b1;
    logic [127:0] CFD_LOAD = '0;
    logic CS_N, SCK, SDI, SDO, SDO_OE_N, BUSY;
    int fail_count = 0;
    int n_tests = 0;
    always #2 MCLK = ~MCLK;
    fsp_top #(.WRITE_CYCLES(300), .PROG_CYCLES(200), .ERASE_CYCLES(600),
        .MAKER_ID(MAKER), .TYPE_ID(MTYPE), .CAPACITY_ID(MCAP)) u_fsp_top (
        .MCLK(MCLK), .RST(RST), .CS_N(CS_N), .SCK(SCK), .SDI(SDI), .WP_N(WP_N),
        .CFD_LOAD(CFD_LOAD), .SDO(SDO), .SDO_OE_N(SDO_OE_N), .BUSY(BUSY));
    fsp_host u_fsp_host (.mclk(MCLK), .cs_n(CS_N), .sck(SCK), .sdi(SDI), .sdo(SDO));
    // ==========================================
    // shared tasks
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    task automatic rd_status(output logic [7:0] s);
        logic [7:0] d;
        u_fsp_host.sel();
        u_fsp_host.xb(C_RS, d);
        u_fsp_host.xb(8'h00, s);
        u_fsp_host.desel();
    endtask
    task automatic exp_status(input logic [7:0] exp, input string what);
        logic [7:0] s;
        rd_status(s);
        chk8(s, exp, what);
    endtask
    task automatic wr_status(input logic [7:0] v, input bit wen);
        logic [7:0] d;
        if (wen) begin
            u_fsp_host.cmd(C_WE);
        end
        u_fsp_host.sel();
        u_fsp_host.xb(fsp_pkg::WRITE_STATUS_CMD, d);
        u_fsp_host.xb(v, d);
        u_fsp_host.desel();
    endtask
    // poll busy, bounded so a stuck cycle cannot hang the run
    task automatic wait_idle();
        logic [7:0] s;
        s = 8'h01;
        for (int k = 0; k < 40 && s[0] !== 1'b0; k++) begin
            rd_status(s);
        end
        chk1(s[0], 1'b0, "busy never cleared");
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset();
        chk1(BUSY, 1'b0, "busy pin after reset");
        chk1(SDO_OE_N, 1'b1, "output enable after reset");
        exp_status(8'h00, "status after reset");
    endtask
    task automatic t_ident();
        logic [7:0] d;
        logic [7:0] hdr [4];
        hdr = '{MAKER, MTYPE, MCAP, 8'h10};
        for (int k = 0; k < 16; k++) begin
            CFD_LOAD[127-8*k -: 8] = 8'(8'ha0 + k);
        end
        u_fsp_host.sel();
        u_fsp_host.xb(C_ID, d);
        for (int n = 0; n < 20; n++) begin
            u_fsp_host.xb(8'h00, d);
            chk8(d, (n < 4) ? hdr[n] : 8'(8'ha0 + n - 4), "ident byte");
        end
        chk1(SDO_OE_N, 1'b0, "output off while reading");
        u_fsp_host.desel();
        chk1(SDO_OE_N, 1'b1, "output kept after deselect");
        CFD_LOAD = '0;
        u_fsp_host.sel();
        u_fsp_host.xb(C_ID, d);
        for (int n = 0; n < 6; n++) begin
            u_fsp_host.xb(8'h00, d);
        end
        chk8(d, 8'h00, "unloaded customer byte");
        u_fsp_host.desel();
        exp_status(8'h00, "status after cut ident");
    endtask
    task automatic t_write();
        logic [7:0] d;
        logic [7:0] s;
        wr_status(8'h9c, 1'b0);
        chk1(BUSY, 1'b0, "write ran without latch");
        exp_status(8'h00, "status after refused write");
        u_fsp_host.cmd(C_WE);
        exp_status(8'h02, "latch after write enable");
        wr_status(8'hff, 1'b0);
        chk1(BUSY, 1'b1, "busy pin in write cycle");
        u_fsp_host.sel();
        u_fsp_host.xb(C_RS, d);
        u_fsp_host.xb(8'h00, s);
        chk8(s, 8'h03, "status during write cycle");
        for (int k = 0; k < 8 && s[0] !== 1'b0; k++) begin
            u_fsp_host.xb(8'h00, s);
        end
        u_fsp_host.desel();
        chk8(s, 8'h9c, "status after write cycle");
        chk1(BUSY, 1'b0, "busy pin after write cycle");
        u_fsp_host.cmd(C_WE);
        u_fsp_host.sel();
        u_fsp_host.xb(fsp_pkg::WRITE_STATUS_CMD, d);
        u_fsp_host.xb(8'h00, d);
        u_fsp_host.xb(8'h00, d);
        u_fsp_host.desel();
        chk1(BUSY, 1'b0, "overlong write ran");
        u_fsp_host.cmd(fsp_pkg::CLEAR_WRITE_ENABLE_CMD);
        exp_status(8'h9c, "status after overlong write and clear");
    endtask
    task automatic t_protect();
        WP_N = 1'b0;
        wr_status(8'h00, 1'b1);
        chk1(BUSY, 1'b0, "write ran in hardware protection");
        exp_status(8'h9e, "status held in hardware protection");
        WP_N = 1'b1;
        wr_status(8'h00, 1'b1);
        wait_idle();
        exp_status(8'h00, "status after leaving protection");
        WP_N = 1'b0;
        wr_status(8'h80, 1'b1);
        wait_idle();
        exp_status(8'h80, "disable bit with pin low");
        wr_status(8'h00, 1'b1);
        chk1(BUSY, 1'b0, "write ran after pin then bit");
        WP_N = 1'b1;
        wr_status(8'h04, 1'b1);
        wait_idle();
        exp_status(8'h04, "block protect set");
    endtask
    task automatic t_erase();
        logic [7:0] d;
        u_fsp_host.cmd(C_WE);
        u_fsp_host.sel();
        u_fsp_host.xb(fsp_pkg::SECTOR_ERASE_CMD, d);
        for (int k = 0; k < 3; k++) begin
            u_fsp_host.xb(8'h00, d);
        end
        u_fsp_host.desel();
        chk1(BUSY, 1'b0, "protected sector erase ran");
        u_fsp_host.cmd(C_WE);
        u_fsp_host.cmd(fsp_pkg::BULK_ERASE_CMD);
        chk1(BUSY, 1'b0, "bulk erase ran with block protect");
        wr_status(8'h00, 1'b1);
        wait_idle();
        u_fsp_host.cmd(C_WE);
        u_fsp_host.cmd(fsp_pkg::BULK_ERASE_CMD);
        chk1(BUSY, 1'b1, "bulk erase did not start");
        u_fsp_host.sel();
        u_fsp_host.xb(C_ID, d);
        u_fsp_host.xb(8'h00, d);
        chk1(SDO_OE_N, 1'b1, "ident answered while erasing");
        u_fsp_host.desel();
        chk1(BUSY, 1'b1, "erase cut short by ident");
        wait_idle();
        exp_status(8'h00, "latch after bulk erase");
        u_fsp_host.cmd(C_WE);
        u_fsp_host.sel();
        u_fsp_host.xb(fsp_pkg::PAGE_PROGRAM_CMD, d);
        for (int k = 0; k < 4; k++) begin
            u_fsp_host.xb(8'h5a, d);
        end
        u_fsp_host.desel();
        chk1(BUSY, 1'b1, "page program did not start");
        wait_idle();
        exp_status(8'h00, "latch after page program");
    endtask
    // ==========================================
    // run control
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge MCLK);
        @(negedge MCLK);
        RST = 1'b0;
        u_fsp_host.wait_clk(8);
        t_reset();
        t_ident();
        t_write();
        t_protect();
        t_erase();
        wrap_up();
    end
    // whole run needs about 20k clocks, limit set well beyond
    initial begin
        #200000;
        fail_count++;
        wrap_up();
    end
endmodule
